// file: rtl/vor_top.sv
// command registers for input turn-off threshold, current offset trim and overvoltage response
//
// Contract
// - written turn-off threshold rounds to nearest 0.25 V step.
// - out-of-range turn-off write sets comms fault, invalid data, alert.
// - out-of-range turn-off write keeps the old threshold.
// - turn-off codes 16 to 30 accepted; reset code is 16.
// - turn-off must stay below start threshold; violating writes rejected and flagged.
// - turn-off word: fixed exponent 11110, only low mantissa bits writable.
// - store-all copies threshold, trim and response settings to nonvolatile memory.
// - trim offsets current readback and overcurrent fault/warning comparisons.
// - trim is 62.5 mA per step, -4 A to +3.9375 A, resets to zero.
// - out-of-span trim wraps; exponent reads 11100, four bits follow the sign.
// - trim mantissa: writable sign, four extension bits, six writable low bits.
// - overvoltage fault sets summary, wide summary and output status flags plus alert.
// - loop slave: response command ignored, nacked, invalid command flagged, alert.
// - default response is shutdown and restart after seven rise times.
// - ignore select 0 keeps running but flags; 1 shuts down, then retries or holds per the retry setting.
// - retry 000 holds output off until cleared; 111 retries indefinitely.
// - retry values other than 000 or 111 rejected and flagged.
// - only retry bit 5 is stored; all three restored from it.
// - retry delay bits mirror bit 5: 000 no delay, 111 seven rise times.
// - start threshold covers 4.25 V to 7.75 V in 0.25 V steps.
`include "vor_regs.svh"
`default_nettype none
module vor_top
  import vor_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_link_clk,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic [7:0] i_cmd_code,
  input wire logic i_cmd_write,
  input wire logic [15:0] i_cmd_wdata,
  output logic o_ans_valid,
  output logic [15:0] o_ans_data,
  output logic o_ans_nack,
  input wire logic [4:0] i_start_code,
  input wire logic i_ov_fault,
  input wire logic i_loop_slave,
  input wire logic i_enable,
  input wire logic i_rise_tick,
  input wire logic i_clear_faults,
  input wire logic i_store_all,
  input wire logic i_nvm_load,
  input wire logic [4:0] i_nvm_off,
  input wire logic [6:0] i_nvm_trim,
  input wire logic i_nvm_ign,
  input wire logic i_nvm_retry,
  output logic o_nvm_save,
  output logic [4:0] o_nvm_off,
  output logic [6:0] o_nvm_trim,
  output logic o_nvm_ign,
  output logic o_nvm_retry,
  input wire logic [11:0] i_iout_raw,
  input wire logic [12:0] i_oc_fault_lim,
  input wire logic [12:0] i_oc_warn_lim,
  output logic [12:0] o_iout_corr,
  output logic o_oc_fault,
  output logic o_oc_warn,
  output logic o_output_en,
  output logic o_status_cml,
  output logic o_status_ivd,
  output logic o_status_badcmd,
  output logic o_status_ov,
  output logic o_status_wide_vout,
  output logic o_vout_ov,
  output logic o_alert
);

  // any exponent near the fixed one is rescaled to quarter volts with round-half-up
  function automatic logic [12:0] vor_to_quarter(input vor_word_t w);
    logic [12:0] m;
    m = {2'h0, w[10:0]};
    unique case (w[15:11])
      5'h1F: vor_to_quarter = {m[11:0], 1'b0};
      5'h1D: vor_to_quarter = 13'((m + 13'h0001) >> 1);
      5'h1C: vor_to_quarter = 13'((m + 13'h0002) >> 2);
      default: vor_to_quarter = m;
    endcase
  endfunction : vor_to_quarter

  // link side: request words held steady until the core acknowledges by toggle
  logic l_req_tgl_reg, l_busy_reg, l_wr_reg;
  logic [7:0] l_code_reg;
  vor_word_t l_wdata_reg;
  logic l_ack_s1, l_ack_s2, l_ack_s3;
  logic c_ack_tgl_reg, c_nack_reg;
  vor_word_t c_rdata_reg;
  // the request word is read by the core only after the toggle has crossed, so it needs no synchroniser
  wire l_ack_evt = l_ack_s2 ^ l_ack_s3;
  wire l_take = i_cmd_valid & ~l_busy_reg;
  assign o_cmd_ready = ~l_busy_reg;

  always_ff @(posedge i_link_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      l_req_tgl_reg <= 1'b0;
      l_busy_reg <= 1'b0;
      l_wr_reg <= 1'b0;
      l_code_reg <= 8'h00;
      l_wdata_reg <= 16'h0000;
      {l_ack_s1, l_ack_s2, l_ack_s3} <= 3'h0;
      o_ans_valid <= 1'b0;
      o_ans_data <= 16'h0000;
      o_ans_nack <= 1'b0;
    end
    else
    begin
      {l_ack_s1, l_ack_s2, l_ack_s3} <= {c_ack_tgl_reg, l_ack_s1, l_ack_s2};
      o_ans_valid <= l_ack_evt;
      if (l_ack_evt)
      begin
        o_ans_data <= c_rdata_reg;
        o_ans_nack <= c_nack_reg;
      end
      if (l_take)
      begin
        l_code_reg <= i_cmd_code;
        l_wr_reg <= i_cmd_write;
        l_wdata_reg <= i_cmd_wdata;
        l_req_tgl_reg <= ~l_req_tgl_reg;
      end
      // busy drops with the answer pulse, so the next request may follow straight away
      l_busy_reg <= l_take | (l_busy_reg & ~l_ack_evt);
    end
  end

  // core side synchronisers
  // the fault pin and the strap change at any time, so neither first stage is read
  logic c_req_s1, c_req_s2, c_req_s3;
  logic ov_s1, ov_s2, ov_s3, slv_s1, slv_s2;
  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      {c_req_s1, c_req_s2, c_req_s3, ov_s1, ov_s2, ov_s3, slv_s1, slv_s2} <= 8'h00;
    else
    begin
      {c_req_s1, c_req_s2, c_req_s3} <= {l_req_tgl_reg, c_req_s1, c_req_s2};
      {ov_s1, ov_s2, ov_s3} <= {i_ov_fault, ov_s1, ov_s2};
      {slv_s1, slv_s2} <= {i_loop_slave, slv_s1};
    end
  end

  logic [4:0] off_reg;
  logic [6:0] trim_reg;
  logic ign_reg, retry_reg;
  logic cml_reg, ivd_reg, badcmd_reg, ovs_reg, wide_reg, vout_ov_reg;
  vor_fault_state_t st_reg, st_next;
  logic [2:0] cnt_reg, cnt_next;

  wire req_evt = c_req_s2 ^ c_req_s3;
  wire ov_evt = ov_s2 & ~ov_s3;
  wire hit_off = l_code_reg == `VOR_ADDR_INPUT_OFF;
  wire hit_trim = l_code_reg == `VOR_ADDR_CUR_TRIM;
  wire hit_ovr = l_code_reg == `VOR_ADDR_OV_RESP;
  wire ovr_blocked = hit_ovr & slv_s2;
  wire ovr_open = hit_ovr & ~slv_s2;
  wire known = hit_off | hit_trim | ovr_open;
  wire wr = req_evt & l_wr_reg;
  wire [12:0] off_q = vor_to_quarter(l_wdata_reg);
  wire off_ok = off_q >= `VOR_OFF_MIN && off_q <= `VOR_OFF_MAX && off_q[4:0] < i_start_code;
  wire [2:0] retry_w = l_wdata_reg[`VOR_RETRY_HI:`VOR_RETRY_LO];
  wire retry_ok = retry_w == 3'h0 || retry_w == 3'h7;
  wire bad_data = wr & ((hit_off & ~off_ok) | (ovr_open & ~retry_ok));
  wire bad_cmd = req_evt & ovr_blocked;

  wire [4:0] off_next = i_nvm_load ? i_nvm_off : (wr & hit_off & off_ok) ? off_q[4:0] : off_reg;
  // exponent and extension bits of the written word are dropped, so values wrap
  wire [6:0] trim_next = i_nvm_load ? i_nvm_trim :
    (wr & hit_trim) ? {l_wdata_reg[10], l_wdata_reg[5:0]} : trim_reg;
  // a rejected retry value leaves ignore select untouched as well
  wire ovr_wr = wr & ovr_open & retry_ok;
  wire ign_next = i_nvm_load ? i_nvm_ign : ovr_wr ? l_wdata_reg[`VOR_IGN_BIT] : ign_reg;
  wire retry_next = i_nvm_load ? i_nvm_retry : ovr_wr ? l_wdata_reg[`VOR_RETRY_HI] : retry_reg;

  wire [10:0] trim_mant = {trim_reg[6], {4{trim_reg[6]}}, trim_reg[5:0]};
  wire [15:0] rd_off = {`VOR_OFF_EXP, 6'h00, off_reg};
  wire [15:0] rd_trim = {`VOR_TRIM_EXP, trim_mant};
  wire [15:0] rd_ovr = {8'h00, ign_reg, 1'b0, {6{retry_reg}}};
  // unknown and blocked codes read as zero; the nack tells the host why
  wire [15:0] rd_sel = hit_off ? rd_off : hit_trim ? rd_trim : ovr_open ? rd_ovr : 16'h0000;

  // set wins over clear on every sticky flag
  wire clr = i_clear_faults;
  wire cml_next = (cml_reg & ~clr) | bad_data;
  wire ivd_next = (ivd_reg & ~clr) | bad_data;
  wire badcmd_next = (badcmd_reg & ~clr) | bad_cmd;
  wire ovs_next = (ovs_reg & ~clr) | ov_evt;
  wire wide_next = (wide_reg & ~clr) | ov_evt;
  wire vout_ov_next = (vout_ov_reg & ~clr) | ov_evt;

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      off_reg <= `VOR_OFF_RST;
      trim_reg <= `VOR_TRIM_RST;
      ign_reg <= `VOR_IGN_RST;
      retry_reg <= `VOR_RETRY_RST;
      {cml_reg, ivd_reg, badcmd_reg, ovs_reg, wide_reg, vout_ov_reg} <= 6'h00;
      o_alert <= 1'b0;
      c_ack_tgl_reg <= 1'b0;
      c_nack_reg <= 1'b0;
      c_rdata_reg <= 16'h0000;
    end
    else
    begin
      off_reg <= off_next;
      trim_reg <= trim_next;
      ign_reg <= ign_next;
      retry_reg <= retry_next;
      {cml_reg, ivd_reg, badcmd_reg} <= {cml_next, ivd_next, badcmd_next};
      {ovs_reg, wide_reg, vout_ov_reg} <= {ovs_next, wide_next, vout_ov_next};
      // alert follows the next flag values so it rises together with the flag
      o_alert <= cml_next | ivd_next | badcmd_next | ovs_next | wide_next | vout_ov_next;
      if (req_evt)
      begin
        c_rdata_reg <= rd_sel;
        c_nack_reg <= ~known;
        c_ack_tgl_reg <= ~c_ack_tgl_reg;
      end
    end
  end

  assign o_status_cml = cml_reg;
  assign o_status_ivd = ivd_reg;
  assign o_status_badcmd = badcmd_reg;
  assign o_status_ov = ovs_reg;
  assign o_status_wide_vout = wide_reg;
  assign o_vout_ov = vout_ov_reg;

  // fault response sequencer
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg;
    unique case (st_reg)
      ST_RUN:
        if (ov_evt & ign_reg)
        begin
          st_next = retry_reg ? ST_WAIT : ST_HOLD;
          cnt_next = 3'h0;
        end
      ST_HOLD:
        if (clr)
          st_next = ST_RUN;
      ST_WAIT:
        // dropping enable abandons the wait; the next start is an ordinary soft start
        if (!i_enable)
          st_next = ST_RUN;
        else if (i_rise_tick)
        begin
          // the wait ends at the seventh tick, so the count never wraps into an early restart
          cnt_next = 3'(cnt_reg + 3'h1);
          if (cnt_reg == 3'(`VOR_RETRY_RISES - 3'h1))
            st_next = ST_RUN;
        end
    endcase
  end

  // sum and comparator results registered together; the comparators see the unregistered sum
  wire [12:0] trim_ext = {{2{trim_mant[10]}}, trim_mant};
  wire [12:0] corr = 13'({i_iout_raw[11], i_iout_raw} + trim_ext);

  always_ff @(posedge i_ref_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      st_reg <= ST_RUN;
      cnt_reg <= 3'h0;
      o_output_en <= 1'b0;
      o_iout_corr <= 13'h0000;
      o_oc_fault <= 1'b0;
      o_oc_warn <= 1'b0;
      o_nvm_save <= 1'b0;
      o_nvm_off <= 5'h00;
      o_nvm_trim <= 7'h00;
      o_nvm_ign <= 1'b0;
      o_nvm_retry <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      o_output_en <= i_enable & (st_next == ST_RUN);
      o_iout_corr <= corr;
      o_oc_fault <= $signed(corr) >= $signed(i_oc_fault_lim);
      o_oc_warn <= $signed(corr) >= $signed(i_oc_warn_lim);
      o_nvm_save <= i_store_all;
      // store-all copies the live values; rounding already happened when they were written
      if (i_store_all)
      begin
        o_nvm_off <= off_reg;
        o_nvm_trim <= trim_reg;
        o_nvm_ign <= ign_reg;
        o_nvm_retry <= retry_reg;
      end
    end
  end

  // checkers on the core clock; the link handshake is judged by the bench
  a_off_keep_old: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr & hit_off & ~off_ok & ~i_nvm_load |=> off_reg == $past(off_reg))
    else $error("turn-off threshold changed on rejected write");
  a_off_flags_set: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr & hit_off & ~off_ok |=> cml_reg & ivd_reg & o_alert)
    else $error("rejected threshold write not flagged");
  a_off_order_kept: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr & hit_off & ~i_nvm_load & off_q[4:0] >= i_start_code |=> off_reg == $past(off_reg))
    else $error("threshold accepted at or above start threshold");
  a_retry_reject: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    wr & ovr_open & ~retry_ok & ~i_nvm_load |=> retry_reg == $past(retry_reg) && ivd_reg)
    else $error("bad retry value not rejected");
  a_slave_nack: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    req_evt & ovr_blocked |=> c_nack_reg & badcmd_reg & o_alert)
    else $error("loop slave access not refused");
  a_ov_flags: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    ov_evt |=> ovs_reg & wide_reg & vout_ov_reg & o_alert)
    else $error("overvoltage event not flagged");
  a_ignore_runs: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    st_reg == ST_RUN & ov_evt & ~ign_reg |=> st_reg == ST_RUN)
    else $error("ignore mode shut down");
  a_hold_off: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    st_reg == ST_HOLD & ~clr |=> st_reg == ST_HOLD && !o_output_en)
    else $error("latched-off output came back");
  a_wait_seven: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    st_reg == ST_WAIT & i_enable & i_rise_tick & cnt_reg == 3'h6 |=> st_reg == ST_RUN ##0 o_output_en)
    else $error("restart not after seventh rise");
  a_early_restart: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    st_reg == ST_WAIT & i_enable & cnt_reg < 3'h6 |=> st_reg == ST_WAIT)
    else $error("restart before seven rises");
  a_nvm_copy: assert property (@(posedge i_ref_clk) disable iff (!i_rstn)
    i_store_all |=> o_nvm_save && o_nvm_off == $past(off_reg) && o_nvm_trim == $past(trim_reg))
    else $error("store-all copy wrong");

endmodule : vor_top
`default_nettype wire

// file: rtl/vor_regs.svh
// register offsets, field positions and reset values of the threshold/offset/response bank
`ifndef VOR_REGS_SVH
`define VOR_REGS_SVH
`define VOR_ADDR_INPUT_OFF 8'h36
`define VOR_ADDR_CUR_TRIM 8'h39
`define VOR_ADDR_OV_RESP 8'h41
`define VOR_OFF_EXP 5'h1E
`define VOR_TRIM_EXP 5'h1C
`define VOR_OFF_MIN 13'h0010
`define VOR_OFF_MAX 13'h001E
`define VOR_OFF_RST 5'h10
`define VOR_TRIM_RST 7'h00
`define VOR_IGN_RST 1'h1
`define VOR_RETRY_RST 1'h1
`define VOR_IGN_BIT 7
`define VOR_RETRY_HI 5
`define VOR_RETRY_LO 3
`define VOR_RETRY_RISES 3'h7
`endif

// file: rtl/vor_pkg.sv
// types shared by the threshold/offset/response bank
`default_nettype none
package vor_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_WAIT} vor_fault_state_t;
  typedef logic [15:0] vor_word_t;
endpackage : vor_pkg
`default_nettype wire

// file: tb/vor_host_model.sv
// host controller model driving the command port from the link clock
`default_nettype none
module vor_host_model (
  input wire logic i_link_clk,
  input wire logic i_cmd_ready,
  input wire logic i_ans_valid,
  input wire logic [15:0] i_ans_data,
  input wire logic i_ans_nack,
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic o_cmd_write,
  output logic [15:0] o_cmd_wdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_write = 1'b0;
    o_cmd_wdata = 16'h0000;
  end
  // one request in flight; released code and data lines invert so a stale word never passes for a live one
  task automatic xfer(input logic [7:0] c, input logic w, input logic [15:0] d, output logic [15:0] rd,
                      output logic nk);
    int n;
    logic rdy;
    n = 0;
    @(posedge i_link_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd_code = c;
    o_cmd_write = w;
    o_cmd_wdata = d;
    // ready is taken where it settled, before the edge that takes the request
    do
    begin
      rdy = i_cmd_ready;
      @(posedge i_link_clk);
      n++;
    end
    while (rdy !== 1'b1 && n < 20);
    #1;
    o_cmd_valid = 1'b0;
    o_cmd_code = ~c;
    o_cmd_wdata = ~d;
    n = 0;
    do
    begin
      @(posedge i_link_clk);
      #1;
      n++;
    end
    while (i_ans_valid !== 1'b1 && n < 10);
    rd = (n < 10) ? i_ans_data : 16'hXXXX;
    nk = i_ans_nack;
  endtask : xfer
endmodule : vor_host_model
`default_nettype wire

// file: tb/vor_top_tb.sv
// self-checking bench for the threshold, trim and overvoltage response bank
`default_nettype none
module vor_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk, i_link_clk, i_cmd_valid, i_cmd_write, o_cmd_ready, o_ans_valid, o_ans_nack;
  logic i_rstn = 1'b0, i_enable = 1'b1, i_ov_fault = 1'b0, i_loop_slave = 1'b0, i_rise_tick = 1'b0;
  logic i_clear_faults = 1'b0, i_store_all = 1'b0, i_nvm_load = 1'b0, i_nvm_ign = 1'b1, i_nvm_retry = 1'b0;
  logic [7:0] i_cmd_code;
  logic [15:0] i_cmd_wdata, o_ans_data;
  logic [4:0] i_start_code = 5'h1F, i_nvm_off = 5'h14, o_nvm_off;
  logic [6:0] i_nvm_trim = 7'h41, o_nvm_trim, flg;
  logic [11:0] i_iout_raw = 12'h064;
  logic [12:0] i_oc_fault_lim = 13'h0069, i_oc_warn_lim = 13'h006A, o_iout_corr;
  logic o_nvm_save, o_nvm_ign, o_nvm_retry, o_oc_fault, o_oc_warn, o_output_en, o_status_cml, o_status_ivd;
  logic o_status_badcmd, o_status_ov, o_status_wide_vout, o_vout_ov, o_alert;
  int errors = 0;
  int tests_run = 0;
  assign flg = {o_status_cml, o_status_ivd, o_status_badcmd, o_status_ov, o_status_wide_vout, o_vout_ov, o_alert};
  vor_top uut (.i_ref_clk, .i_rstn, .i_link_clk, .i_cmd_valid, .o_cmd_ready, .i_cmd_code, .i_cmd_write,
    .i_cmd_wdata, .o_ans_valid, .o_ans_data, .o_ans_nack, .i_start_code, .i_ov_fault, .i_loop_slave, .i_enable,
    .i_rise_tick, .i_clear_faults, .i_store_all, .i_nvm_load, .i_nvm_off, .i_nvm_trim, .i_nvm_ign, .i_nvm_retry,
    .o_nvm_save, .o_nvm_off, .o_nvm_trim, .o_nvm_ign, .o_nvm_retry, .i_iout_raw, .i_oc_fault_lim, .i_oc_warn_lim,
    .o_iout_corr, .o_oc_fault, .o_oc_warn, .o_output_en, .o_status_cml, .o_status_ivd, .o_status_badcmd,
    .o_status_ov, .o_status_wide_vout, .o_vout_ov, .o_alert);
  vor_host_model host (.i_link_clk, .i_cmd_ready(o_cmd_ready), .i_ans_valid(o_ans_valid), .i_ans_data(o_ans_data),
    .i_ans_nack(o_ans_nack), .o_cmd_valid(i_cmd_valid), .o_cmd_code(i_cmd_code), .o_cmd_write(i_cmd_write),
    .o_cmd_wdata(i_cmd_wdata));
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  // odd start offset keeps the link clock out of phase with the core clock
  initial
  begin
    i_link_clk = 1'b0;
    #3;
    forever #32 i_link_clk = ~i_link_clk;
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask : cyc
  task automatic cmd(input logic [7:0] c, input logic w, input logic [15:0] d, input logic [15:0] e, input logic n);
    logic [15:0] got;
    logic nk;
    host.xfer(c, w, d, got, nk);
    cyc(1);
    chk(got, e);
    chk({15'h0000, nk}, {15'h0000, n});
  endtask : cmd
  // a write answers with the value held before it
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic [15:0] e);
    cmd(c, 1'b1, d, e, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    cmd(c, 1'b0, 16'h0000, e, 1'b0);
  endtask : rd
  task automatic fl(input logic [6:0] e);
    chk({9'h000, flg}, {9'h000, e});
  endtask : fl
  task automatic en(input logic e);
    chk({15'h0000, o_output_en}, {15'h0000, e});
  endtask : en
  task automatic clr;
    i_ov_fault = 1'b0;
    i_clear_faults = 1'b1;
    cyc(1);
    i_clear_faults = 1'b0;
    cyc(3);
  endtask : clr
  task automatic ov_on;
    i_ov_fault = 1'b1;
    cyc(6);
  endtask : ov_on
  task automatic tick(input int n);
    repeat (n)
    begin
      i_rise_tick = 1'b1;
      cyc(1);
      i_rise_tick = 1'b0;
      cyc(1);
    end
  endtask : tick
  task automatic t_regs;
    rd(8'h36, 16'hF010);
    rd(8'h39, 16'hE000);
    rd(8'h41, 16'h00BF);
    cmd(8'h00, 1'b0, 16'h0000, 16'h0000, 1'b1);
    fl(7'h00);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_off;
    wr(8'h36, 16'hF014, 16'hF010);
    wr(8'h36, 16'hF01F, 16'hF014);
    rd(8'h36, 16'hF014);
    fl(7'h61);
    clr;
    wr(8'h36, 16'hF01E, 16'hF014);
    wr(8'h36, 16'hF00F, 16'hF01E);
    wr(8'h36, 16'hF809, 16'hF01E);
    rd(8'h36, 16'hF012);
    wr(8'h36, 16'hE821, 16'hF012);
    rd(8'h36, 16'hF011);
    wr(8'h36, 16'hE046, 16'hF011);
    rd(8'h36, 16'hF012);
    clr;
    i_start_code = 5'h12;
    wr(8'h36, 16'hF011, 16'hF012);
    wr(8'h36, 16'hF013, 16'hF011);
    rd(8'h36, 16'hF011);
    fl(7'h61);
    clr;
    i_start_code = 5'h1F;
    $display("t_off done");
  endtask : t_off
  task automatic t_trim;
    wr(8'h39, 16'h07FF, 16'hE000);
    wr(8'h39, 16'h0005, 16'hE7FF);
    rd(8'h39, 16'hE005);
    cyc(3);
    chk({3'h0, o_iout_corr}, 16'h0069);
    chk({14'h0000, o_oc_fault, o_oc_warn}, 16'h0002);
    $display("t_trim done");
  endtask : t_trim
  task automatic t_resp;
    wr(8'h41, 16'h0015, 16'h00BF);
    rd(8'h41, 16'h00BF);
    fl(7'h61);
    clr;
    wr(8'h41, 16'h0047, 16'h00BF);
    rd(8'h41, 16'h0000);
    $display("t_resp done");
  endtask : t_resp
  task automatic t_ov;
    ov_on;
    fl(7'h0F);
    en(1'b1);
    clr;
    wr(8'h41, 16'h0080, 16'h0000);
    ov_on;
    tick(8);
    en(1'b0);
    clr;
    en(1'b1);
    wr(8'h41, 16'h00BF, 16'h0080);
    ov_on;
    tick(6);
    en(1'b0);
    tick(1);
    en(1'b1);
    clr;
    $display("t_ov done");
  endtask : t_ov
  task automatic t_nvm;
    i_store_all = 1'b1;
    cyc(1);
    i_store_all = 1'b0;
    chk({1'b0, o_nvm_save, o_nvm_off, o_nvm_trim, o_nvm_ign, o_nvm_retry}, 16'h6217);
    i_nvm_load = 1'b1;
    cyc(1);
    i_nvm_load = 1'b0;
    rd(8'h36, 16'hF014);
    rd(8'h39, 16'hE7C1);
    rd(8'h41, 16'h0080);
    $display("t_nvm done");
  endtask : t_nvm
  task automatic t_slave;
    i_loop_slave = 1'b1;
    cyc(4);
    cmd(8'h41, 1'b0, 16'h0000, 16'h0000, 1'b1);
    fl(7'h11);
    clr;
    cmd(8'h41, 1'b1, 16'h00BF, 16'h0000, 1'b1);
    i_loop_slave = 1'b0;
    cyc(4);
    rd(8'h41, 16'h0080);
    $display("t_slave done");
  endtask : t_slave
  task automatic close_out;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  initial
  begin
    #200000;
    errors++;
    close_out;
  end
  initial
  begin
    repeat (20) @(posedge i_ref_clk);
    #1;
    i_rstn = 1'b1;
    cyc(4);
    t_regs;
    t_off;
    t_trim;
    t_resp;
    t_ov;
    t_nvm;
    t_slave;
    close_out;
  end
endmodule : vor_top_tb
`default_nettype wire
